// ---- keypad_scan_controller.sv ----
// Key-matrix controller: constants package and the top-level module.
// How it works
// - Watch 64 keys; queue events in a sixteen-entry seven-bit FIFO.
// - Idle columns stay driven; scanning starts only when a row changes.
// - Debounce; queue each press and release; autorepeat queues extra presses.
// - With autosleep on, sleep after the programmed idle time since last event.
// - Sleep keeps FIFO contents; reads still pop entries while asleep.
// - The idle timer never sleeps the block while a key is held.
// - With autowake on, a key press during sleep restores operation.
// - Autosleep and autowake can each be switched off by configuration.
// - Interrupt fires at a FIFO fill level, or at most once per period.
// - One read of the FIFO register returns next event plus status bits.
// - Interrupt pin is active low, open drain.
// - Interrupt pin may instead be a software-set open-drain output.
// - Columns 2 to 7 may each become open-drain outputs, dropping eight keys.
// - Columns 0 and 1 are always matrix column drivers.
// - The address-select input picks one of four slave addresses.
// - Eight row inputs; a grounded or idle row means no key activity.
// - Reset loads power-up register values and starts in sleep.
// - Entry key number is column times eight plus row, bits 5 to 0.
// - Bit 7 means more data, bit 6 release; keys 62 and 63 force bit 7.
// - FIFO reads clear the interrupt as configuration bit 5 selects.
// - Empty reads 0x3F; overflow reads 0x7F, then reading continues.
package keypad_scan_pkg;
    localparam logic [7:0] ADDR_FIFO = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h01;
    localparam logic [7:0] ADDR_DEBOUNCE = 8'h02;
    localparam logic [7:0] ADDR_INT = 8'h03;
    localparam logic [7:0] ADDR_PORTS = 8'h04;
    localparam logic [7:0] ADDR_REPEAT = 8'h05;
    localparam logic [7:0] ADDR_SLEEP = 8'h06;
    localparam logic [7:0] RST_CFG = 8'h0A;
    localparam logic [7:0] RST_DEBOUNCE = 8'hFF;
    localparam logic [7:0] RST_INT = 8'h00;
    localparam logic [7:0] RST_PORTS = 8'hFE;
    localparam logic [7:0] RST_REPEAT = 8'h00;
    localparam logic [7:0] RST_SLEEP = 8'h07;
    localparam int CFG_RUN_BIT = 7;
    localparam int CFG_INTCLR_BIT = 5;
    localparam int CFG_RELEASE_BIT = 3;
    localparam int CFG_AUTOWAKE_BIT = 1;
    localparam int INT_MODE_BIT = 7;
    localparam int PORT_INT_GPO_BIT = 0;
    localparam int PORT_INT_LEVEL_BIT = 1;
    localparam int REPEAT_EN_BIT = 7;
    localparam logic [7:0] EMPTY_CODE = 8'h3F;
    localparam logic [7:0] OVERFLOW_CODE = 8'h7F;
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h38;
    localparam int CLK_HZ = 200_000_000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYCLES = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999)
        / 1000;
    localparam int DEBOUNCE_BASE_MS = 9;
    localparam int REPEAT_DELAY_UNIT_MS = 32;
    localparam int REPEAT_RATE_UNIT_MS = 16;
    localparam int SLEEP_UNIT_MS = 256;
    localparam int INT_PERIOD_UNIT_MS = 8;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_DEBOUNCE = 4'b0010,
        S_SCAN = 4'b0100,
        S_COMPARE = 4'b1000
    } scan_state_t;
endpackage : keypad_scan_pkg

`timescale 1ns/10ps
module keypad_scan_controller
    import keypad_scan_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Key matrix
    input wire logic [7:0] matrix_row_in,
    output logic [7:0] matrix_col_out,
    output logic [7:0] matrix_col_oe_n_out,
    // Interrupt or general-purpose open-drain pin
    output logic int_n_out,
    output logic int_oe_n_out,
    // Address selection
    input wire logic [1:0] slave_addr_select_in,
    output logic [6:0] slave_addr_out
);
    localparam int FAW = $clog2(FIFO_DEPTH);

    logic [7:0] cfg_r, cfg_nxt, deb_r, deb_nxt, intc_r, intc_nxt;
    logic [7:0] ports_r, ports_nxt, rep_r, rep_nxt, slp_r, slp_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic ovf_r, ovf_nxt, int_pend_r, int_pend_nxt;
    logic [11:0] idle_ms_r, idle_ms_nxt;
    logic [8:0] per_ms_r, per_ms_nxt;
    scan_state_t st_r, st_nxt;
    logic [63:0] keys_r, keys_nxt, new_r, new_nxt;
    logic [5:0] idx_r, idx_nxt, held_r, held_nxt;
    logic held_v_r, held_v_nxt;
    logic [9:0] rep_ms_r, rep_ms_nxt;
    logic rep_first_r, rep_first_nxt;
    logic [5:0] deb_ms_r, deb_ms_nxt;
    logic [7:0] base_r, base_nxt, last_r, last_nxt;
    logic [15:0] settle_r, settle_nxt;
    logic [31:0] ms_cnt_r;
    logic ms_tick_r;
    logic [7:0] row_meta_r, row_s_r;
    logic [1:0] asel_meta_r, asel_s_r;
    logic addr_done_r;
    logic [6:0] slave_addr_r;
    logic push, pop, fifo_full, fifo_empty;
    logic [6:0] push_data, head;
    logic [FAW:0] count;
    logic [7:0] head_byte, gpo_cols, drive_cols;
    logic rd_fifo;

    // Column c is a general-purpose output when it lies above the highest
    // matrix column kept; columns 0 and 1 can never be converted.
    function automatic logic col_is_gpo(input logic [7:0] d, input int c);
        logic [2:0] top;
        top = (d[7:5] < 3'h1) ? 3'h1 : d[7:5];
        return (c >= 2) && (3'(c) > top);
    endfunction : col_is_gpo

    function automatic logic [11:0] ms_of(input logic [7:0] code,
                                          input int unit);
        return 12'(code * unit);
    endfunction : ms_of

    key_event_fifo #(.WIDTH(7), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .push_in(push),
        .data_in(push_data),
        .pop_in(pop),
        .head_out(head),
        .count_out(count),
        .full_out(fifo_full),
        .empty_out(fifo_empty)
    );

    // Inputs from pins cross two flops; the timebase is free running.
    always_ff @(posedge clk_in)
    begin
        row_meta_r <= matrix_row_in;
        row_s_r <= row_meta_r;
        asel_meta_r <= slave_addr_select_in;
        asel_s_r <= asel_meta_r;
        if (rst_in)
        begin
            ms_cnt_r <= '0;
            ms_tick_r <= 1'b0;
            addr_done_r <= 1'b0;
            slave_addr_r <= SLAVE_ADDR_BASE;
        end
        else
        begin
            ms_tick_r <= (ms_cnt_r == 32'(MS_TICK_CYCLES - 1));
            ms_cnt_r <= (ms_cnt_r == 32'(MS_TICK_CYCLES - 1)) ? '0
                : ms_cnt_r + 1'b1;
            if (!addr_done_r)
            begin
                addr_done_r <= 1'b1;
                slave_addr_r <= SLAVE_ADDR_BASE | {5'h00, asel_s_r};
            end
        end
    end

    always_comb
    begin
        gpo_cols = '0;
        drive_cols = '0;
        for (int c = 0; c < 8; c++)
        begin
            gpo_cols[c] = col_is_gpo(deb_r, c);
            drive_cols[c] = !gpo_cols[c]
                && ((st_r != S_SCAN) || (idx_r[2:0] == 3'(c)));
        end
        head_byte = {(count > (FAW + 1)'(1)) || (head[5:1] == 5'h1F),
                     head};
        rd_fifo = reg_rd_in && (reg_addr_in == ADDR_FIFO);
        pop = rd_fifo && !ovf_r && !fifo_empty;
    end

    // Scan engine: debounce, column-by-column sampling, event generation.
    always_comb
    begin
        st_nxt = st_r;
        keys_nxt = keys_r;
        new_nxt = new_r;
        idx_nxt = idx_r;
        held_nxt = held_r;
        held_v_nxt = held_v_r;
        rep_ms_nxt = rep_ms_r;
        rep_first_nxt = rep_first_r;
        deb_ms_nxt = deb_ms_r;
        base_nxt = base_r;
        last_nxt = last_r;
        settle_nxt = settle_r;
        push = 1'b0;
        push_data = '0;
        case (st_r)
            S_IDLE:
            begin
                if (cfg_r[CFG_RUN_BIT] && row_s_r != base_r)
                begin
                    st_nxt = S_DEBOUNCE;
                    deb_ms_nxt = '0;
                    last_nxt = row_s_r;
                end
                else if (cfg_r[CFG_RUN_BIT] && rep_r[REPEAT_EN_BIT]
                         && held_v_r && ms_tick_r)
                begin
                    rep_ms_nxt = rep_ms_r + 1'b1;
                    if (rep_ms_r >= (rep_first_r
                        ? 10'(ms_of({4'h0, rep_r[3:0]} + 8'h01,
                                    REPEAT_DELAY_UNIT_MS))
                        : 10'(ms_of({5'h00, rep_r[6:4]} + 8'h01,
                                    REPEAT_RATE_UNIT_MS))))
                    begin
                        push = 1'b1;
                        push_data = {1'b0, held_r};
                        rep_ms_nxt = '0;
                        rep_first_nxt = 1'b0;
                    end
                end
            end
            S_DEBOUNCE:
            begin
                last_nxt = row_s_r;
                if (row_s_r != last_r)
                begin
                    deb_ms_nxt = '0;
                end
                else if (ms_tick_r)
                begin
                    deb_ms_nxt = deb_ms_r + 1'b1;
                    if (deb_ms_r >= 6'({1'b0, deb_r[4:0]}
                                       + DEBOUNCE_BASE_MS))
                    begin
                        st_nxt = S_SCAN;
                        idx_nxt = '0;
                        settle_nxt = '0;
                    end
                end
            end
            S_SCAN:
            begin
                settle_nxt = settle_r + 1'b1;
                if (settle_r == 16'(SETTLE_CYCLES - 1))
                begin
                    settle_nxt = '0;
                    new_nxt[{idx_r[2:0], 3'h0} +: 8] =
                        gpo_cols[idx_r[2:0]] ? 8'h00 : row_s_r;
                    idx_nxt = idx_r + 1'b1;
                    if (idx_r[2:0] == 3'h7)
                    begin
                        st_nxt = S_COMPARE;
                        idx_nxt = '0;
                    end
                end
            end
            S_COMPARE:
            begin
                if (new_r[idx_r] != keys_r[idx_r])
                begin
                    keys_nxt[idx_r] = new_r[idx_r];
                    push = new_r[idx_r] || cfg_r[CFG_RELEASE_BIT];
                    push_data = {!new_r[idx_r], idx_r};
                    if (new_r[idx_r])
                    begin
                        held_nxt = idx_r;
                        held_v_nxt = 1'b1;
                        rep_ms_nxt = '0;
                        rep_first_nxt = 1'b1;
                    end
                    else if (held_r == idx_r)
                    begin
                        held_v_nxt = 1'b0;
                    end
                end
                idx_nxt = idx_r + 1'b1;
                if (idx_r == 6'h3F)
                begin
                    st_nxt = S_IDLE;
                    base_nxt = row_s_r;
                end
            end
            default:
            begin
                st_nxt = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_r <= S_IDLE;
            keys_r <= '0;
            new_r <= '0;
            idx_r <= '0;
            held_r <= '0;
            held_v_r <= 1'b0;
            rep_ms_r <= '0;
            rep_first_r <= 1'b1;
            deb_ms_r <= '0;
            base_r <= '0;
            last_r <= '0;
            settle_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            keys_r <= keys_nxt;
            new_r <= new_nxt;
            idx_r <= idx_nxt;
            held_r <= held_nxt;
            held_v_r <= held_v_nxt;
            rep_ms_r <= rep_ms_nxt;
            rep_first_r <= rep_first_nxt;
            deb_ms_r <= deb_ms_nxt;
            base_r <= base_nxt;
            last_r <= last_nxt;
            settle_r <= settle_nxt;
        end
    end

    // Registers, sleep control and interrupt generation.
    always_comb
    begin
        cfg_nxt = cfg_r;
        deb_nxt = deb_r;
        intc_nxt = intc_r;
        ports_nxt = ports_r;
        rep_nxt = rep_r;
        slp_nxt = slp_r;
        ovf_nxt = ovf_r;
        int_pend_nxt = int_pend_r;
        idle_ms_nxt = idle_ms_r;
        per_ms_nxt = per_ms_r;
        rdata_nxt = '0;
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                ADDR_CFG: cfg_nxt = reg_wdata_in;
                ADDR_DEBOUNCE: deb_nxt = reg_wdata_in;
                ADDR_INT: intc_nxt = reg_wdata_in;
                ADDR_PORTS: ports_nxt = reg_wdata_in;
                ADDR_REPEAT: rep_nxt = reg_wdata_in;
                ADDR_SLEEP: slp_nxt = reg_wdata_in;
                default: cfg_nxt = cfg_r;
            endcase
        end
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                ADDR_FIFO: rdata_nxt = ovf_r ? OVERFLOW_CODE
                    : (fifo_empty ? EMPTY_CODE : head_byte);
                ADDR_CFG: rdata_nxt = cfg_r;
                ADDR_DEBOUNCE: rdata_nxt = deb_r;
                ADDR_INT: rdata_nxt = intc_r;
                ADDR_PORTS: rdata_nxt = ports_r;
                ADDR_REPEAT: rdata_nxt = rep_r;
                ADDR_SLEEP: rdata_nxt = slp_r;
                default: rdata_nxt = '0;
            endcase
        end
        if (rd_fifo && ovf_r)
        begin
            ovf_nxt = 1'b0;
        end
        // An event lost beside the clearing read must still be flagged.
        if (push && fifo_full && !pop)
        begin
            ovf_nxt = 1'b1;
        end
        // Idle time restarts on every queued event and while a key is held.
        if (push || (|keys_r) || !cfg_r[CFG_RUN_BIT])
        begin
            idle_ms_nxt = '0;
        end
        else if (ms_tick_r && slp_r[2:0] != 3'h0)
        begin
            idle_ms_nxt = idle_ms_r + 1'b1;
            if (idle_ms_r >= ms_of({5'h00, slp_r[2:0]}, SLEEP_UNIT_MS))
            begin
                cfg_nxt[CFG_RUN_BIT] = 1'b0;
            end
        end
        if (!cfg_r[CFG_RUN_BIT] && cfg_r[CFG_AUTOWAKE_BIT]
            && (|row_s_r))
        begin
            cfg_nxt[CFG_RUN_BIT] = 1'b1;
        end
        // Clearing happens first so a simultaneous trigger still wins.
        if (rd_fifo && (!cfg_r[CFG_INTCLR_BIT]
                        || count <= (FAW + 1)'(1)))
        begin
            int_pend_nxt = 1'b0;
        end
        if (!intc_r[INT_MODE_BIT])
        begin
            if (intc_r[4:0] != 5'h00 && push
                && count + 1'b1 == (FAW + 1)'(intc_r[4:0]))
            begin
                int_pend_nxt = 1'b1;
            end
        end
        else if (ms_tick_r && intc_r[4:0] != 5'h00)
        begin
            per_ms_nxt = per_ms_r + 1'b1;
            if (per_ms_r >= 9'(ms_of({3'h0, intc_r[4:0]},
                                     INT_PERIOD_UNIT_MS)))
            begin
                per_ms_nxt = '0;
                int_pend_nxt = int_pend_nxt || !fifo_empty;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cfg_r <= RST_CFG;
            deb_r <= RST_DEBOUNCE;
            intc_r <= RST_INT;
            ports_r <= RST_PORTS;
            rep_r <= RST_REPEAT;
            slp_r <= RST_SLEEP;
            rdata_r <= '0;
            ovf_r <= 1'b0;
            int_pend_r <= 1'b0;
            idle_ms_r <= '0;
            per_ms_r <= '0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            deb_r <= deb_nxt;
            intc_r <= intc_nxt;
            ports_r <= ports_nxt;
            rep_r <= rep_nxt;
            slp_r <= slp_nxt;
            rdata_r <= rdata_nxt;
            ovf_r <= ovf_nxt;
            int_pend_r <= int_pend_nxt;
            idle_ms_r <= idle_ms_nxt;
            per_ms_r <= per_ms_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;
    assign slave_addr_out = slave_addr_r;
    // Open-drain pins only ever pull low; a matrix column drives high.
    assign matrix_col_out = ~gpo_cols;
    assign matrix_col_oe_n_out = (gpo_cols & ports_r)
        | ~(gpo_cols | drive_cols);
    assign int_n_out = 1'b0;
    assign int_oe_n_out = ports_r[PORT_INT_GPO_BIT]
        ? ports_r[PORT_INT_LEVEL_BIT] : !int_pend_r;

    a_empty_read_code: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_fifo && fifo_empty && !ovf_r |=> reg_rdata_out == 8'h3F)
        else $error("empty FIFO read did not return 0x3F");
    a_overflow_read: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_fifo && ovf_r |=> reg_rdata_out == 8'h7F
        && (!ovf_r || $past(push && fifo_full)))
        else $error("overflow read wrong");
    a_read_pops_one: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_fifo && !ovf_r && !fifo_empty && !push
        |=> count == $past(count) - 1'b1)
        else $error("FIFO read did not pop one entry");
    a_no_sleep_held: assert property (@(posedge clk_in) disable iff (rst_in)
        cfg_r[CFG_RUN_BIT] && (|keys_r) && !reg_wr_in
        |=> cfg_r[CFG_RUN_BIT])
        else $error("slept while a key was held");
    a_autowake_press: assert property (@(posedge clk_in) disable iff (rst_in)
        !cfg_r[CFG_RUN_BIT] && cfg_r[CFG_AUTOWAKE_BIT] && (|row_s_r)
        && !reg_wr_in |=> cfg_r[CFG_RUN_BIT])
        else $error("autowake failed");
    a_level_int_pin: assert property (@(posedge clk_in) disable iff (rst_in)
        !intc_r[INT_MODE_BIT] && push && !fifo_full && !rd_fifo
        && intc_r[4:0] != 5'h00 && count + 1'b1 == (FAW + 1)'(intc_r[4:0])
        && !ports_r[PORT_INT_GPO_BIT] && !reg_wr_in
        |=> !int_oe_n_out)
        else $error("level interrupt not raised");
    a_col_low_fixed: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r == S_IDLE |-> matrix_col_oe_n_out[1:0] == 2'b00
        && matrix_col_out[1:0] == 2'b11)
        else $error("column 0 or 1 not driving");
    a_event_key_num: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r == S_COMPARE && push |-> push_data[5:0] == idx_r
        && push_data[6] == !new_r[idx_r])
        else $error("queued key number wrong");
    a_reset_asleep: assert property (@(posedge clk_in)
        rst_in |=> !cfg_r[CFG_RUN_BIT] && cfg_r == RST_CFG)
        else $error("reset did not start in sleep");
endmodule : keypad_scan_controller

// ---- key_event_fifo.sv ----
// Small synchronous FIFO that queues debounced key events.
`timescale 1ns/10ps
module key_event_fifo #(
    parameter int WIDTH = 7,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Filling side
    input wire logic push_in,
    input wire logic [WIDTH-1:0] data_in,
    // Draining side
    input wire logic pop_in,
    output logic [WIDTH-1:0] head_out,
    output logic [AW:0] count_out,
    output logic full_out,
    output logic empty_out
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic push_ok;
    logic pop_ok;

    always_comb
    begin
        // A pop in the same cycle frees a slot, so that push is kept.
        push_ok = push_in && ((count_r != (AW + 1)'(DEPTH)) || pop_in);
        pop_ok = pop_in && (count_r != '0);
        wr_ptr_nxt = push_ok ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = pop_ok ? rd_ptr_r + 1'b1 : rd_ptr_r;
        count_nxt = count_r;
        if (push_ok && !pop_ok)
        begin
            count_nxt = count_r + 1'b1;
        end
        else if (pop_ok && !push_ok)
        begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
        end
        if (push_ok)
        begin
            mem_r[wr_ptr_r] <= data_in;
        end
    end

    assign head_out = mem_r[rd_ptr_r];
    assign count_out = count_r;
    assign full_out = (count_r == (AW + 1)'(DEPTH));
    assign empty_out = (count_r == '0);
endmodule : key_event_fifo

// ---- key_matrix_model.sv ----
// Behavioural key matrix holding at most one closed switch.
`timescale 1ns/10ps
module key_matrix_model (
    // Column drive from the controller
    input wire logic [7:0] col_in,
    input wire logic [7:0] col_oe_n_in,
    // Bit 6 set while the key in bits 5 to 0 is held
    input wire logic [6:0] key_in,
    // Row sense
    output logic [7:0] row_out
);
    logic [2:0] col;
    logic [2:0] row;
    assign col = key_in[5:3];
    assign row = key_in[2:0];
    // Undriven rows sit at ground, so only a driven closed key shows.
    always_comb
    begin
        row_out = 8'h00;
        if (key_in[6] && !col_oe_n_in[col] && col_in[col])
        begin
            row_out[row] = 1'b1;
        end
    end
endmodule : key_matrix_model

// ---- testbench.sv ----
// Self-checking bench for the key-matrix controller.
`timescale 1ns/10ps
module testbench;
    localparam int EV = 2200;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] rdata, rows, cols, col_oe_n;
    logic int_n, int_oe_n;
    logic [1:0] sel = 2'h0;
    logic [6:0] slave_addr;
    logic [6:0] key = 7'h00;
    logic [5:0] k;
    logic [7:0] exp_q[$];
    logic [7:0] rst_vals[8] = '{8'h3F, 8'h0A, 8'hFF, 8'h00, 8'hFE, 8'h00,
        8'h07, 8'h00};
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int seed = 32'h8ce2;
    always #2.5 clk_in = ~clk_in;
    // Short timebase and FIFO keep every timer and overflow reachable.
    keypad_scan_controller #(.MS_TICK_CYCLES(20), .FIFO_DEPTH(4)) dut (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .reg_addr_in(addr),
        .reg_wdata_in(wdata),
        .reg_wr_in(wr_s),
        .reg_rd_in(rd_s),
        .reg_rdata_out(rdata),
        .matrix_row_in(rows),
        .matrix_col_out(cols),
        .matrix_col_oe_n_out(col_oe_n),
        .int_n_out(int_n),
        .int_oe_n_out(int_oe_n),
        .slave_addr_select_in(sel),
        .slave_addr_out(slave_addr)
    );
    key_matrix_model matrix (
        .col_in(cols),
        .col_oe_n_in(col_oe_n),
        .key_in(key),
        .row_out(rows)
    );
    task automatic check(input string name, input logic [7:0] e,
        input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask : check
    task automatic finish_test();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_in);
        wr_s <= 1'b0;
        @(posedge clk_in);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        @(posedge clk_in);
    endtask : rd
    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
    endtask : hold
    // Read data stand only in the cycle after the strobe.
    always @(posedge clk_in) rd_d <= rd_s;
    always @(negedge clk_in)
    begin
        if (rd_d)
            check("read data", exp_q.pop_front(), rdata);
    end
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    initial
    begin
        sel <= 2'($unsigned($random(seed)));
        hold(3);
        rst_in <= 1'b0;
        hold(1);
        check("int pin", 8'h01, {7'h0, int_oe_n});
        for (int a = 0; a < 8; a++)
            rd(8'(a), rst_vals[a]);
        check("slave", {1'b0, 7'h38 | {5'h0, sel}}, {1'b0, slave_addr});
        check("int level", 8'h00, {7'h0, int_n});
        wr(8'h02, 8'hE0);
        wr(8'h03, 8'h01);
        wr(8'h01, 8'h88);
        for (int i = 0; i < 5; i++)
        begin
            k = (i < 3) ? 6'($unsigned($random(seed)) % 62) : 6'(59 + i);
            key <= {1'b1, k};
            hold(EV);
            check("int pin", 8'h00, {7'h0, int_oe_n});
            rd(8'h00, {k > 6'd61, 1'b0, k});
            hold(3);
            check("int pin", 8'h01, {7'h0, int_oe_n});
            key <= {1'b0, k};
            hold(EV);
            rd(8'h00, {k > 6'd61, 1'b1, k});
            rd(8'h00, 8'h3F);
        end
        for (int i = 0; i < 3; i++)
        begin
            key <= {1'b1, 6'(i * 9)};
            hold(EV);
            key <= {1'b0, 6'(i * 9)};
            hold(EV);
        end
        rd(8'h00, 8'h7F);
        rd(8'h00, 8'h80);
        rd(8'h00, 8'hC0);
        rd(8'h00, 8'h89);
        rd(8'h00, 8'h49);
        rd(8'h00, 8'h3F);
        key <= 7'h45;
        hold(EV);
        wr(8'h01, 8'h00);
        rd(8'h00, 8'h05);
        key <= 7'h05;
        hold(EV);
        rd(8'h00, 8'h3F);
        wr(8'h01, 8'h02);
        key <= 7'h53;
        hold(EV);
        rd(8'h01, 8'h82);
        key <= 7'h13;
        hold(EV);
        wr(8'h06, 8'h01);
        hold(5400);
        rd(8'h01, 8'h02);
        rd(8'h00, 8'h13);
        check("int pin", 8'h01, {7'h0, int_oe_n});
        wr(8'h02, 8'h20);
        wr(8'h04, 8'hA9);
        check("column enables", 8'hA8, col_oe_n);
        check("column levels", 8'h03, cols);
        check("int pin", 8'h00, {7'h0, int_oe_n});
        wr(8'h04, 8'hAB);
        check("int pin", 8'h01, {7'h0, int_oe_n});
        hold(4);
        finish_test();
    end
endmodule : testbench
